// ===== hdl/servo_motion_command_handler.sv
`timescale 1ns/1ps
`default_nettype none
`include "smch_map.svh"
module servo_motion_command_handler
    import smch_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        reset,
    // Command bytes from the packet framer
    input  wire logic [7:0]  rx_byte,
    input  wire logic        rx_valid,
    // Servo loop and amplifier feedback
    input  wire logic [15:0] pos_err_abs,
    input  wire logic [7:0]  motor_current,
    input  wire logic [15:0] pwm_demand,
    input  wire logic        raw_pwm_mode,
    input  wire logic        status_brake,
    // Pins
    input  wire logic        reverse_limit,
    input  wire logic        forward_limit,
    input  wire logic        index_pin,
    input  wire logic        supply_ok,
    // Filter parameters
    output logic      [14:0] proportional_gain,
    output logic      [14:0] derivative_gain,
    output logic      [14:0] integral_gain,
    output logic      [14:0] integration_limit,
    output logic      [7:0]  output_limit,
    output logic      [7:0]  current_limit,
    output logic      [13:0] position_error_limit,
    output logic      [7:0]  servo_rate_divisor,
    // Drive control
    output logic             power_driver_enable,
    output logic             servo_enable,
    output logic             velocity_mode,
    output logic      [15:0] pwm_out,
    output logic             current_limit_active,
    output logic             brake_out,
    // Timebase
    output logic             servo_tick,
    output logic             path_point_tick,
    output logic      [14:0] path_point_count,
    // Profiler events
    output logic             traj_start,
    output logic             traj_buffered,
    output logic             stop_abrupt,
    output logic             stop_smooth,
    output logic             stop_jump,
    output logic      [31:0] stop_position,
    // Homing and status
    output logic             homing_in_progress,
    output logic             home_capture,
    output logic             status_power_on,
    output logic             status_reverse_limit,
    output logic             status_forward_limit
);
    localparam logic [10:0] TICK_LAST = 11'(`SMCH_TICK_CYC - 1);

    smch_state_t q;
    smch_state_t n;
    logic [7:0]  rd_data;
    logic [3:0]  edges;
    logic [7:0]  home_ev;
    logic        perr;
    logic        trig;

    smch_byte_ram u_ram (
        .clk_sys (clk_sys),
        .reset   (reset),
        .wr_en   (q.state == SMCH_COLLECT && rx_valid),
        .wr_addr (q.idx),
        .wr_data (rx_byte),
        .rd_addr (q.widx),
        .rd_data (rd_data)
    );

    always_comb begin
        n = q;
        n.servo_tick    = 1'b0;
        n.path_tick     = 1'b0;
        n.traj_start    = 1'b0;
        n.traj_buffered = 1'b0;
        n.stop_abrupt   = 1'b0;
        n.stop_smooth   = 1'b0;
        n.stop_jump     = 1'b0;
        n.home_capture  = 1'b0;
        n.sync1 = {supply_ok, index_pin, forward_limit, reverse_limit};
        n.sync2 = q.sync1;
        n.prev  = q.sync2;
        edges   = q.sync2 ^ q.prev;
        perr    = pos_err_abs > {2'h0, q.el};
        home_ev = {q.cl_active, perr, 2'b00, edges[2], 1'b0, edges[1:0]};
        trig    = q.homing && |(q.home_mask & home_ev & `SMCH_HOME_EV_MASK);
        // Base tick, then divided servo and path ticks
        n.base_tick = (q.base_cnt == TICK_LAST);
        n.base_cnt  = n.base_tick ? 11'h000 : q.base_cnt + 11'h001;
        if (q.base_tick) begin
            if (q.sr_cnt >= q.sr) begin
                n.sr_cnt     = 8'h01;
                n.servo_tick = 1'b1;
            end else begin
                n.sr_cnt = q.sr_cnt + 8'h01;
            end
            if (q.path_count != 15'h0000) begin
                if (q.pp_cnt >= q.path_count) begin
                    n.pp_cnt    = 15'h0001;
                    n.path_tick = 1'b1;
                end else begin
                    n.pp_cnt = q.pp_cnt + 15'h0001;
                end
            end
        end
        // Home trigger acts before a new command so a fresh set wins
        if (trig) begin
            n.homing       = 1'b0;
            n.home_capture = 1'b1;
            if (q.home_mask[`SMCH_HOME_OFF]) begin
                n.servo_en = 1'b0;
                n.pwm_zero = 1'b1;
            end else if (q.home_mask[`SMCH_HOME_ABRUPT]) begin
                n.servo_en    = 1'b1;
                n.vel_mode    = 1'b1;
                n.stop_abrupt = 1'b1;
            end else if (q.home_mask[`SMCH_HOME_SMOOTH]) begin
                n.vel_mode    = 1'b1;
                n.stop_smooth = 1'b1;
            end
        end
        case (q.state)
            SMCH_IDLE: begin
                if (rx_valid) begin
                    n.cmd  = rx_byte[3:0];
                    n.cnt  = rx_byte[7:4];
                    n.idx  = 4'h0;
                    n.state = (rx_byte[7:4] == 4'h0) ? SMCH_EXEC
                                                     : SMCH_COLLECT;
                end
            end
            SMCH_COLLECT: begin
                if (rx_valid) begin
                    n.idx = q.idx + 4'h1;
                    if (q.idx == q.cnt - 4'h1) begin
                        n.state  = SMCH_WALK;
                        n.widx   = 4'h0;
                        n.rvalid = 1'b0;
                    end
                end
            end
            SMCH_WALK: begin
                n.widx   = q.widx + 4'h1;
                n.rvalid = 1'b1;
                n.ridx   = q.widx;
                if (q.rvalid) begin
                    if (q.ridx == 4'h0) begin
                        n.st_ctrl = rd_data;
                    end
                    case (q.cmd)
                        `SMCH_CMD_GAIN: begin
                            case (q.ridx)
                                `SMCH_GAIN_KP:        n.kp[7:0]  = rd_data;
                                `SMCH_GAIN_KP + 4'h1: n.kp[14:8] = rd_data[6:0];
                                `SMCH_GAIN_KD:        n.kd[7:0]  = rd_data;
                                `SMCH_GAIN_KD + 4'h1: n.kd[14:8] = rd_data[6:0];
                                `SMCH_GAIN_KI:        n.ki[7:0]  = rd_data;
                                `SMCH_GAIN_KI + 4'h1: n.ki[14:8] = rd_data[6:0];
                                `SMCH_GAIN_IL:        n.il[7:0]  = rd_data;
                                `SMCH_GAIN_IL + 4'h1: n.il[14:8] = rd_data[6:0];
                                `SMCH_GAIN_OL:        n.ol       = rd_data;
                                `SMCH_GAIN_CL:        n.cl       = rd_data;
                                `SMCH_GAIN_EL:        n.el[7:0]  = rd_data;
                                `SMCH_GAIN_EL + 4'h1: n.el[13:8] = rd_data[5:0];
                                `SMCH_GAIN_SR:        n.sr = (rd_data == 8'h00)
                                                        ? 8'h01 : rd_data;
                                default: ;
                            endcase
                        end
                        `SMCH_CMD_STOP: begin
                            case (q.ridx)
                                4'h1: n.st_pos[7:0]   = rd_data;
                                4'h2: n.st_pos[15:8]  = rd_data;
                                4'h3: n.st_pos[23:16] = rd_data;
                                4'h4: n.st_pos[31:24] = rd_data;
                                default: ;
                            endcase
                        end
                        `SMCH_CMD_IO: begin
                            case (q.ridx)
                                4'h1: n.st_path[7:0]  = rd_data;
                                4'h2: n.st_path[14:8] = rd_data[6:0];
                                default: ;
                            endcase
                        end
                        default: ;
                    endcase
                    if (q.ridx == q.cnt - 4'h1) begin
                        n.state = SMCH_EXEC;
                    end
                end
            end
            SMCH_EXEC: begin
                n.state = SMCH_IDLE;
                case (q.cmd)
                    `SMCH_CMD_START: begin
                        n.traj_start   = 1'b1;
                        n.traj_pending = 1'b0;
                    end
                    `SMCH_CMD_LOAD: begin
                        if (q.cnt != 4'h0 && q.st_ctrl[`SMCH_LOAD_NOW]) begin
                            n.traj_start   = 1'b1;
                            n.traj_pending = 1'b0;
                        end else if (q.cnt != 4'h0) begin
                            n.traj_buffered = 1'b1;
                            n.traj_pending  = 1'b1;
                        end
                    end
                    `SMCH_CMD_STOP: begin
                        n.drv_en = q.st_ctrl[`SMCH_STOP_DRV];
                        // One action only; lower bit wins if host errs
                        if (q.st_ctrl[`SMCH_STOP_OFF]) begin
                            n.servo_en = 1'b0;
                            n.pwm_zero = 1'b1;
                        end else if (q.st_ctrl[`SMCH_STOP_ABRUPT]) begin
                            n.servo_en    = 1'b1;
                            n.vel_mode    = 1'b1;
                            n.pwm_zero    = 1'b0;
                            n.stop_abrupt = 1'b1;
                        end else if (q.st_ctrl[`SMCH_STOP_SMOOTH]) begin
                            n.vel_mode    = 1'b1;
                            n.stop_smooth = 1'b1;
                        end else if (q.st_ctrl[`SMCH_STOP_HERE] &&
                                     q.cnt >= `SMCH_STOP_POS_LEN) begin
                            n.stop_pos  = q.st_pos;
                            n.stop_jump = 1'b1;
                        end
                    end
                    `SMCH_CMD_IO: begin
                        n.brake_mode_select  = q.st_ctrl[`SMCH_IO_BRAKE_MODE];
                        n.brake_manual_state = q.st_ctrl[`SMCH_IO_BRAKE_STATE];
                        if (q.st_ctrl[`SMCH_IO_PATH] && q.cnt >= 4'h3) begin
                            n.path_count = q.st_path;
                            n.pp_cnt     = 15'h0001;
                        end
                    end
                    `SMCH_CMD_HOME: begin
                        n.home_mask = q.st_ctrl;
                        n.homing    = 1'b1;
                    end
                    default: ;
                endcase
            end
            default: n.state = SMCH_IDLE;
        endcase
        if (n.traj_start) begin
            n.servo_en = ~raw_pwm_mode;
            n.pwm_zero = 1'b0;
            n.vel_mode = 1'b0;
        end
        if (q.servo_en && perr) begin
            n.servo_en = 1'b0;
            n.pwm_zero = 1'b1;
        end
        // Output stage
        if (q.pwm_zero) begin
            n.pwm = 16'h0000;
        end else if (q.servo_en) begin
            n.pwm = (pwm_demand > {8'h00, q.ol}) ? {8'h00, q.ol} : pwm_demand;
        end else if (raw_pwm_mode) begin
            n.pwm = pwm_demand;
        end else begin
            n.pwm = 16'h0000;
        end
        n.cl_active   = (q.cl != 8'h00) && (motor_current > q.cl);
        n.brake_out   = q.brake_mode_select ? q.brake_manual_state
                                            : status_brake;
        n.st_power_on = q.drv_en & q.sync2[3];
        n.st_rev      = q.drv_en & q.sync2[0];
        n.st_fwd      = q.drv_en & q.sync2[1];
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            q        <= '0;
            q.state  <= SMCH_IDLE;
            q.ol     <= `SMCH_RST_OL;
            q.sr     <= `SMCH_RST_SR;
            q.sr_cnt <= 8'h01;
            q.pp_cnt <= 15'h0001;
        end else begin
            q <= n;
        end
    end

    assign proportional_gain    = q.kp;
    assign derivative_gain      = q.kd;
    assign integral_gain        = q.ki;
    assign integration_limit    = q.il;
    assign output_limit         = q.ol;
    assign current_limit        = q.cl;
    assign position_error_limit = q.el;
    assign servo_rate_divisor   = q.sr;
    assign power_driver_enable  = q.drv_en;
    assign servo_enable         = q.servo_en;
    assign velocity_mode        = q.vel_mode;
    assign pwm_out              = q.pwm;
    assign current_limit_active = q.cl_active;
    assign brake_out            = q.brake_out;
    assign servo_tick           = q.servo_tick;
    assign path_point_tick      = q.path_tick;
    assign path_point_count     = q.path_count;
    assign traj_start           = q.traj_start;
    assign traj_buffered        = q.traj_buffered;
    assign stop_abrupt          = q.stop_abrupt;
    assign stop_smooth          = q.stop_smooth;
    assign stop_jump            = q.stop_jump;
    assign stop_position        = q.stop_pos;
    assign homing_in_progress   = q.homing;
    assign home_capture         = q.home_capture;
    assign status_power_on      = q.st_power_on;
    assign status_reverse_limit = q.st_rev;
    assign status_forward_limit = q.st_fwd;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    logic exec_stop;
    assign exec_stop = q.state == SMCH_EXEC && q.cmd == `SMCH_CMD_STOP;

    property p_len;
        q.state == SMCH_IDLE && rx_valid && rx_byte[7:4] != 4'h0
            |=> q.state == SMCH_COLLECT && q.cnt == $past(rx_byte[7:4]);
    endproperty
    a_len: assert property (p_len) else $error("length nibble ignored");
    property p_clamp;
        q.servo_en && !q.pwm_zero |=> pwm_out <= {8'h00, $past(q.ol)};
    endproperty
    a_clamp: assert property (p_clamp) else $error("PWM above limit");
    property p_cl_zero;
        q.cl == 8'h00 |=> !current_limit_active;
    endproperty
    a_cl_zero: assert property (p_cl_zero) else $error("limit at zero");
    property p_perr;
        q.servo_en && perr |=> !servo_enable ##1 pwm_out == 16'h0000;
    endproperty
    a_perr: assert property (p_perr) else $error("servo kept on error");
    property p_tick;
        servo_tick |-> $past(q.base_tick) ##1 !servo_tick;
    endproperty
    a_tick: assert property (p_tick) else $error("tick off base");
    property p_drv;
        exec_stop |=> power_driver_enable == $past(q.st_ctrl[0]);
    endproperty
    a_drv: assert property (p_drv) else $error("driver enable wrong");
    property p_off;
        exec_stop && q.st_ctrl[1] |=> !servo_enable && !stop_abrupt
            && !stop_smooth && !stop_jump ##1 pwm_out == 16'h0000;
    endproperty
    a_off: assert property (p_off) else $error("motor off failed");
    property p_abrupt;
        exec_stop && q.st_ctrl[2:1] == 2'b10 && !perr
            |=> stop_abrupt && servo_enable && velocity_mode;
    endproperty
    a_abrupt: assert property (p_abrupt) else $error("abrupt stop");
    property p_brake;
        q.brake_mode_select |=> brake_out == $past(q.brake_manual_state);
    endproperty
    a_brake: assert property (p_brake) else $error("brake source");
    property p_home;
        q.state == SMCH_EXEC && q.cmd == `SMCH_CMD_HOME
            |=> homing_in_progress;
    endproperty
    a_home: assert property (p_home) else $error("homing not set");
    property p_capture;
        home_capture |-> !homing_in_progress || $past(q.state) == SMCH_EXEC;
    endproperty
    a_capture: assert property (p_capture) else $error("homing kept");

    c_gain: cover property (q.state == SMCH_EXEC && q.cmd == `SMCH_CMD_GAIN);
    c_jump: cover property (stop_jump);
    c_home: cover property (home_capture);
    c_path: cover property (path_point_tick);
endmodule
`default_nettype wire

// ===== hdl/smch_byte_ram.sv
`timescale 1ns/1ps
`default_nettype none
module smch_byte_ram
    import smch_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       reset,
    // Write side
    input  wire logic       wr_en,
    input  wire logic [3:0] wr_addr,
    input  wire logic [7:0] wr_data,
    // Read side, data one cycle after address
    input  wire logic [3:0] rd_addr,
    output logic      [7:0] rd_data
);
    smch_ram_t q;
    smch_ram_t n;

    always_comb begin
        n = q;
        if (wr_en) begin
            n.mem[wr_addr] = wr_data;
        end
        n.rd = q.mem[rd_addr];
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign rd_data = q.rd;
endmodule
`default_nettype wire

// ===== hdl/smch_map.svh
`ifndef SMCH_MAP_SVH
`define SMCH_MAP_SVH

// Timing: system clock period and base servo tick (51.2 us)
`define SMCH_CLK_NS         40
`define SMCH_TICK_NS        51200
`define SMCH_TICK_CYC       (`SMCH_TICK_NS / `SMCH_CLK_NS)

// Command values (low nibble of the command byte)
`define SMCH_CMD_LOAD       4'h4
`define SMCH_CMD_START      4'h5
`define SMCH_CMD_GAIN       4'h6
`define SMCH_CMD_STOP       4'h7
`define SMCH_CMD_IO         4'h8
`define SMCH_CMD_HOME       4'h9

// Data byte index of each set-gain field (low byte first)
`define SMCH_GAIN_KP        4'h0
`define SMCH_GAIN_KD        4'h2
`define SMCH_GAIN_KI        4'h4
`define SMCH_GAIN_IL        4'h6
`define SMCH_GAIN_OL        4'h8
`define SMCH_GAIN_CL        4'h9
`define SMCH_GAIN_EL        4'hA
`define SMCH_GAIN_SR        4'hC

// Stop-control bits
`define SMCH_STOP_DRV       0
`define SMCH_STOP_OFF       1
`define SMCH_STOP_ABRUPT    2
`define SMCH_STOP_SMOOTH    3
`define SMCH_STOP_HERE      4
`define SMCH_STOP_POS_LEN   4'h5

// I/O-control bits
`define SMCH_IO_BRAKE_MODE  0
`define SMCH_IO_BRAKE_STATE 1
`define SMCH_IO_PATH        6

// Homing-control bits
`define SMCH_HOME_OFF       2
`define SMCH_HOME_ABRUPT    4
`define SMCH_HOME_SMOOTH    5
`define SMCH_HOME_EV_MASK   8'hCB

// Load-trajectory immediate-start bit
`define SMCH_LOAD_NOW       7

// Reset values
`define SMCH_RST_OL         8'hFA
`define SMCH_RST_SR         8'h01

`endif

// ===== hdl/smch_pkg.sv
package smch_pkg;

    typedef enum logic [3:0] {
        SMCH_IDLE    = 4'h1,
        SMCH_COLLECT = 4'h2,
        SMCH_WALK    = 4'h4,
        SMCH_EXEC    = 4'h8
    } smch_fsm_t;

    typedef struct packed {
        logic [15:0][7:0] mem;
        logic [7:0]       rd;
    } smch_ram_t;

    typedef struct packed {
        smch_fsm_t   state;
        logic [3:0]  cmd;
        logic [3:0]  cnt;
        logic [3:0]  idx;
        logic [3:0]  widx;
        logic        rvalid;
        logic [3:0]  ridx;
        logic [7:0]  st_ctrl;
        logic [31:0] st_pos;
        logic [14:0] st_path;
        logic [14:0] kp;
        logic [14:0] kd;
        logic [14:0] ki;
        logic [14:0] il;
        logic [7:0]  ol;
        logic [7:0]  cl;
        logic [13:0] el;
        logic [7:0]  sr;
        logic        drv_en;
        logic        servo_en;
        logic        vel_mode;
        logic        pwm_zero;
        logic        brake_mode_select;
        logic        brake_manual_state;
        logic        traj_pending;
        logic [31:0] stop_pos;
        logic [14:0] path_count;
        logic [7:0]  home_mask;
        logic        homing;
        logic [10:0] base_cnt;
        logic        base_tick;
        logic [7:0]  sr_cnt;
        logic [14:0] pp_cnt;
        logic [3:0]  sync1;
        logic [3:0]  sync2;
        logic [3:0]  prev;
        logic        servo_tick;
        logic        path_tick;
        logic        traj_start;
        logic        traj_buffered;
        logic        stop_abrupt;
        logic        stop_smooth;
        logic        stop_jump;
        logic        home_capture;
        logic [15:0] pwm;
        logic        cl_active;
        logic        brake_out;
        logic        st_power_on;
        logic        st_rev;
        logic        st_fwd;
    } smch_state_t;

endpackage

// ===== test/servo_motion_command_handler_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module servo_motion_command_handler_tb_top;
    logic clk_sys = 1'b0, reset = 1'b1, rx_valid, status_brake = 1'b1;
    logic reverse_limit = 1'b0, forward_limit = 1'b0, supply_ok = 1'b1;
    logic clr = 1'b0;
    logic [7:0]  rx_byte, motor_current = 8'h00;
    logic [15:0] pos_err_abs = 16'h0000, pwm_demand = 16'hFFFF, pwm_out;
    logic [14:0] proportional_gain, derivative_gain, integral_gain;
    logic [14:0] integration_limit, path_point_count;
    logic [7:0]  output_limit, current_limit, servo_rate_divisor;
    logic [13:0] position_error_limit;
    logic [31:0] stop_position;
    logic [5:0]  ev;
    logic        power_driver_enable, servo_enable, velocity_mode, brake_out;
    logic        current_limit_active, servo_tick, path_point_tick;
    logic        traj_start, stop_abrupt, stop_smooth, stop_jump;
    logic        homing_in_progress, home_capture, status_reverse_limit;
    logic        status_power_on, status_forward_limit, traj_buffered;
    int          n_mismatch = 0;
    int          n_checks = 0;

    smch_host_model i_smch_host_model (.clk_sys, .rx_byte, .rx_valid);
    servo_motion_command_handler i_servo_motion_command_handler (
        .clk_sys, .reset, .rx_byte, .rx_valid, .pos_err_abs, .motor_current,
        .pwm_demand, .raw_pwm_mode(1'b0), .status_brake, .reverse_limit,
        .forward_limit, .index_pin(1'b0), .supply_ok,
        .proportional_gain, .derivative_gain, .integral_gain,
        .integration_limit, .output_limit, .current_limit,
        .position_error_limit, .servo_rate_divisor, .power_driver_enable,
        .servo_enable, .velocity_mode, .pwm_out, .current_limit_active,
        .brake_out, .servo_tick, .path_point_tick, .path_point_count,
        .traj_start, .traj_buffered, .stop_abrupt, .stop_smooth,
        .stop_jump, .stop_position, .homing_in_progress, .home_capture,
        .status_power_on, .status_reverse_limit, .status_forward_limit);

    initial forever #20 clk_sys = ~clk_sys;
    // Sticky record of one-cycle event pulses
    always @(posedge clk_sys) begin
        ev <= clr ? 6'h00 : ev | {traj_buffered, home_capture, stop_jump,
                                  stop_smooth, stop_abrupt, traj_start};
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cmd(input logic [127:0] p);
        @(posedge clk_sys);
        clr <= 1'b1;
        @(posedge clk_sys);
        clr <= 1'b0;
        i_smch_host_model.send(p);
        repeat (20) @(posedge clk_sys);
        #1;
    endtask

    // Cycles between two pulses of a tick output
    task automatic gap(input bit path, input int exp);
        int n;
        n = 0;
        do #40; while ((path ? path_point_tick : servo_tick) !== 1'b1);
        do begin #40; n++; end
        while ((path ? path_point_tick : servo_tick) !== 1'b1);
        chk(n, exp);
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        #1;
        chk(output_limit, 8'hFA);
        chk(power_driver_enable, 1'b0);
        cmd(128'h00AA_023F_FF05_8040_0000_0112_347F_FFE6);
        chk(proportional_gain, 15'h7FFF);
        chk(derivative_gain, 15'h1234);
        chk(integral_gain, 15'h0001);
        chk(integration_limit, 15'h4000);
        chk(output_limit, 8'h80);
        chk(current_limit, 8'h05);
        chk(position_error_limit, 14'h3FFF);
        chk(servo_rate_divisor, 8'h02);
        gap(1'b0, 2560);
        $display("gain test done");
        cmd(16'h0517);
        chk({power_driver_enable, servo_enable, velocity_mode}, 3'h7);
        chk(ev, 5'h02);
        chk(pwm_out, 16'h0080);
        motor_current <= 8'h06;
        cmd(16'h2119);
        chk(current_limit_active, 1'b1);
        chk(homing_in_progress, 1'b1);
        {reverse_limit, forward_limit} <= 2'h3;
        repeat (10) @(posedge clk_sys);
        #1;
        chk(homing_in_progress, 1'b0);
        chk(ev, 5'h14);
        chk({status_reverse_limit, status_forward_limit}, 2'h3);
        chk(status_power_on, 1'b1);
        pos_err_abs <= 16'h4000;
        cmd(16'h0517);
        chk(servo_enable, 1'b0);
        pos_err_abs <= 16'h0000;
        cmd(16'h0517);
        cmd(16'h0317);
        chk({servo_enable, pwm_out}, 17'h0);
        cmd(16'h0817);
        chk({power_driver_enable, status_reverse_limit}, 2'h0);
        chk({status_forward_limit, status_power_on}, 2'h0);
        chk(ev, 5'h04);
        cmd(48'h1234_5678_1157);
        chk(stop_position, 32'h1234_5678);
        chk(ev, 5'h08);
        cmd(16'h1014);
        chk(ev, 6'h20);
        cmd(8'h05);
        chk(ev, 5'h01);
        $display("stop test done");
        cmd(32'h0003_4338);
        chk(brake_out, 1'b1);
        chk(path_point_count, 15'h0003);
        gap(1'b1, 3840);
        cmd(16'h0118);
        chk(brake_out, 1'b0);
        cmd(16'h0018);
        chk(brake_out, 1'b1);
        $display("io test done");
        wrap_up();
    end

    initial begin
        repeat (40000) @(posedge clk_sys);
        n_mismatch++;
        wrap_up();
    end
endmodule
`default_nettype wire

// ===== test/smch_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module smch_host_model (
    // Clock
    input  wire logic       clk_sys,
    // Byte stream to the handler
    output logic      [7:0] rx_byte,
    output logic            rx_valid
);
    initial begin
        rx_byte  = 8'h00;
        rx_valid = 1'b0;
    end
    // Command byte first, data count from its high nibble
    task automatic send(input logic [15:0][7:0] p);
        for (int i = 0; i <= p[0][7:4]; i++) begin
            @(posedge clk_sys);
            rx_byte  <= p[i];
            rx_valid <= 1'b1;
        end
        @(posedge clk_sys);
        rx_valid <= 1'b0;
        rx_byte  <= ~p[p[0][7:4]];
    endtask
endmodule
`default_nettype wire
